//--- verilog/ext_bus_defs.vh
// shared constants of the external bus control block
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// ********************************************************
// space codes carried on the request port
// ********************************************************
`define SPACE_DATA    2'h0
`define SPACE_PROGRAM 2'h1
`define SPACE_IO      2'h2

// ********************************************************
// wait-state policy
// ********************************************************
// least programmed wait states that turn on ready detection
`define READY_MIN_WAITS 3'h2

// ********************************************************
// field positions of the address bus
// ********************************************************
`define ADDR_LOW_MSB  15
`define ADDR_HIGH_LSB 16

// ********************************************************
// reset values of the pin drivers
// ********************************************************
`define RST_SEL_N   1'h1
`define RST_STROBE  1'h1
`define RST_RW      1'h1
`define RST_GRANT_N 1'h1
`define RST_MSC_N   1'h1
`define RST_OE      1'h0

`endif

//--- verilog/pin_sync.v
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             core_clk_i,
  input  wire             srst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  // ********************************************************
  // two stages
  // ********************************************************
  reg [WIDTH-1:0] meta_q;   // first stage, read only by stage two
  reg [WIDTH-1:0] stable_q; // second stage, safe for logic

  // both stages reset to the idle pin level
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q   <= INIT;
      stable_q <= INIT;
    end else begin
      meta_q   <= async_i;
      stable_q <= meta_q;
    end
  end

  assign sync_o = stable_q;

endmodule

`default_nettype wire

//--- verilog/wait_counter.v
// software wait-state down counter
`timescale 1ns/1ps
`default_nettype none

module wait_counter #(
  parameter WS_W = 3
) (
  input  wire            core_clk_i,
  input  wire            srst_i,
  input  wire            load_i,
  input  wire [WS_W-1:0] load_val_i,
  input  wire            dec_i,
  output wire [WS_W-1:0] count_o,
  output reg  [WS_W-1:0] next_o
);

  // ********************************************************
  // counter
  // ********************************************************
  reg [WS_W-1:0] count_q; // wait states still to run

  // next value: load wins, decrement saturates at zero
  always @* begin
    next_o = count_q;
    if (load_i) begin
      next_o = load_val_i;
    end else if (dec_i && (count_q != {WS_W{1'b0}})) begin
      next_o = count_q - {{(WS_W-1){1'b0}}, 1'b1};
    end
  end

  // register the count
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      count_q <= {WS_W{1'b0}};
    end else begin
      count_q <= next_o;
    end
  end

  assign count_o = count_q;

endmodule

`default_nettype wire

//--- verilog/ext_bus_ctrl.v
// control side of the external parallel bus: selects, strobes, waits, hold
//
// How it works
// - space selects idle high, low only when accessing
// - select low exactly while address is valid
// - memory strobe low only for memory access
// - io strobe low only for io access
// - direction high, low only during writes
// - ready low stalls one cycle, then resample
// - ready checked only with two+ wait states
// - ready never sampled before software waits end
// - microstate done low in last wait state, only with two+ wait states
// - looped microstate done adds one extra wait
// - on the edge that grants hold, float address, data, controls
// - grant asserted while floated in hold state
// - hold floats selects, strobes and direction
// - output disable floats all controls, grant, done
// - address bus floats in hold or disable
// - upper seven address lines only for program
// - enabled keeper holds floated data lines level
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
`default_nettype none

module ext_bus_ctrl #(
  parameter AW   = 23, // address lines
  parameter DW   = 16, // data lines
  parameter WS_W = 3   // width of the wait-state count
) (
  input  wire            core_clk_i,
  input  wire            srst_i,
  // core request port
  input  wire            req_valid_i,
  input  wire [1:0]      req_space_i,
  input  wire            req_write_i,
  input  wire [AW-1:0]   req_addr_i,
  input  wire [DW-1:0]   req_wdata_i,
  input  wire [WS_W-1:0] req_wait_i,
  input  wire            keep_en_i,
  output reg             req_ready_o,
  output reg             done_o,
  output reg  [DW-1:0]   rdata_o,
  // bus pins
  input  wire            ready_i,
  input  wire            hold_n_i,
  input  wire            off_n_i,
  input  wire [DW-1:0]   data_i,
  output reg             data_space_sel_n_o,
  output reg             program_space_sel_n_o,
  output reg             io_space_sel_n_o,
  output reg             memory_strobe_n_o,
  output reg             io_strobe_n_o,
  output reg             rw_o,
  output reg             ctrl_oe_o,
  output reg  [AW-1:0]   addr_o,
  output reg             addr_oe_o,
  output reg  [DW-1:0]   data_o,
  output reg             data_oe_o,
  output reg             keep_oe_o,
  output reg             bus_grant_n_o,
  output reg             bus_grant_oe_o,
  output reg             microstate_done_n_o,
  output reg             microstate_done_oe_o
);

  // ********************************************************
  // states
  // ********************************************************
  localparam [2:0] ST_IDLE = 3'h0; // waiting for a request
  localparam [2:0] ST_STRB = 3'h1; // base access cycle
  localparam [2:0] ST_WAIT = 3'h2; // software wait states
  localparam [2:0] ST_SETL = 3'h3; // lets ready cross the synchroniser
  localparam [2:0] ST_RDY  = 3'h4; // sampling ready
  localparam [2:0] ST_END1 = 3'h5; // strobes released
  localparam [2:0] ST_END2 = 3'h6; // read data captured
  localparam [2:0] ST_HOLD = 3'h7; // bus handed to outside master

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  wire          ready_s;  // synchronised ready
  wire          hold_n_s; // synchronised hold request, low active
  wire          off_n_s;  // synchronised output disable, low active
  wire [DW-1:0] data_s;   // synchronised data bus

  // pins idle high except the data bus
  pin_sync #(
    .WIDTH (DW + 3),
    .INIT  ({3'h7, {DW{1'b0}}})
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({ready_i, hold_n_i, off_n_i, data_i}),
    .sync_o     ({ready_s, hold_n_s, off_n_s, data_s})
  );

  // ********************************************************
  // access state
  // ********************************************************
  reg  [2:0]      state_q;  // current state
  reg  [2:0]      state_d;  // next state
  reg  [1:0]      space_q;  // space of the running access
  reg             write_q;  // direction of the running access
  reg  [WS_W-1:0] waits_q;  // programmed wait states of the access
  reg             load;     // request taken this cycle
  reg             dec;      // one wait state done
  wire [WS_W-1:0] cnt;      // wait states left, last one is 1
  wire [WS_W-1:0] cnt_nx;   // count after this edge

  // wait-state counter, loaded when a request is taken
  wait_counter #(
    .WS_W (WS_W)
  ) u_wait_counter (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .load_i     (load),
    .load_val_i (req_wait_i),
    .dec_i      (dec),
    .count_o    (cnt),
    .next_o     (cnt_nx)
  );

  // values of the access seen by the next edge
  wire [1:0]      cur_space = load ? req_space_i : space_q;
  wire            cur_write = load ? req_write_i : write_q;
  wire [WS_W-1:0] cur_waits = load ? req_wait_i : waits_q;
  // ready detection only with enough software waits
  wire            ready_chk = (cur_waits >= `READY_MIN_WAITS);

  // ********************************************************
  // next-state logic
  // ********************************************************
  // a pending hold wins over a new request; a running access
  // is always finished before the bus is granted
  always @* begin
    state_d = state_q;
    load    = 1'b0;
    dec     = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (!hold_n_s) begin
          state_d = ST_HOLD;
        end else if (req_valid_i && req_ready_o) begin
          state_d = ST_STRB;
          load    = 1'b1;
        end
      end
      ST_STRB: begin
        if (waits_q == {WS_W{1'b0}}) begin
          state_d = ST_END1;
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt == {{(WS_W-1){1'b0}}, 1'b1}) begin
          // ready is left alone until the last software wait
          state_d = ready_chk ? ST_SETL : ST_END1;
        end else begin
          dec = 1'b1;
        end
      end
      ST_SETL: begin
        // synchroniser delay; keeps a looped-back done to one extra wait
        state_d = ST_RDY;
      end
      ST_RDY: begin
        // low ready holds here one more cycle and samples again
        if (ready_s) begin
          state_d = ST_END1;
        end
      end
      ST_END1: begin
        state_d = ST_END2;
      end
      ST_END2: begin
        state_d = ST_IDLE;
      end
      ST_HOLD: begin
        // the outside master keeps its request up while it owns the bus
        if (hold_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ********************************************************
  // pin values for the next cycle
  // ********************************************************
  // access window: from base cycle through the last ready sample
  wire active_d = (state_d == ST_STRB) || (state_d == ST_WAIT) ||
                  (state_d == ST_SETL) || (state_d == ST_RDY);
  wire hold_d   = (state_d == ST_HOLD);
  // drivers on only when not in hold and not disabled
  wire drive_d  = off_n_s && !hold_d;
  // done pin low in the last of two or more software waits
  wire msc_d    = (state_d == ST_WAIT) && ready_chk &&
                  (cnt_nx == {{(WS_W-1){1'b0}}, 1'b1});
  // write data drive follows the access window
  wire wdrv_d   = drive_d && active_d && cur_write;

  // ********************************************************
  // registered state and pins
  // ********************************************************
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q               <= ST_IDLE;
      space_q               <= `SPACE_DATA;
      write_q               <= 1'b0;
      waits_q               <= {WS_W{1'b0}};
      req_ready_o           <= 1'b0;
      data_space_sel_n_o    <= `RST_SEL_N;
      program_space_sel_n_o <= `RST_SEL_N;
      io_space_sel_n_o      <= `RST_SEL_N;
      memory_strobe_n_o     <= `RST_STROBE;
      io_strobe_n_o         <= `RST_STROBE;
      rw_o                  <= `RST_RW;
      ctrl_oe_o             <= `RST_OE;
      addr_oe_o             <= `RST_OE;
      data_oe_o             <= `RST_OE;
      bus_grant_n_o         <= `RST_GRANT_N;
      bus_grant_oe_o        <= `RST_OE;
      microstate_done_n_o   <= `RST_MSC_N;
      microstate_done_oe_o  <= `RST_OE;
    end else begin
      state_q     <= state_d;
      req_ready_o <= (state_d == ST_IDLE);
      // latch the attributes of a taken request
      if (load) begin
        space_q <= req_space_i;
        write_q <= req_write_i;
        waits_q <= req_wait_i;
      end
      // selects low only across the address-valid window
      data_space_sel_n_o    <= !(active_d && (cur_space == `SPACE_DATA));
      program_space_sel_n_o <= !(active_d && (cur_space == `SPACE_PROGRAM));
      io_space_sel_n_o      <= !(active_d && (cur_space == `SPACE_IO));
      // memory strobe covers data and program space
      memory_strobe_n_o <= !(active_d && (cur_space != `SPACE_IO));
      io_strobe_n_o     <= !(active_d && (cur_space == `SPACE_IO));
      // direction reads high unless writing
      rw_o <= !(active_d && cur_write);
      // release after ready happens via END1, on the same edge that samples ready
      // control drivers float in hold and when disabled
      ctrl_oe_o <= drive_d;
      addr_oe_o <= drive_d;
      data_oe_o <= wdrv_d;
      // grant goes low together with the lines floating
      bus_grant_n_o  <= !hold_d;
      bus_grant_oe_o <= off_n_s;
      microstate_done_n_o  <= !msc_d;
      microstate_done_oe_o <= off_n_s;
    end
  end

  // ********************************************************
  // address and data paths
  // ********************************************************
  // no reset on the address path; the enables keep it off the bus during reset, in hold and when disabled
  always @(posedge core_clk_i) begin
    if (load) begin
      // upper lines carry address only for program space
      if (req_space_i == `SPACE_PROGRAM) begin
        addr_o <= req_addr_i;
      end else begin
        addr_o <= {{(AW-`ADDR_HIGH_LSB){1'b0}},
                   req_addr_i[`ADDR_LOW_MSB:0]};
      end
    end
  end

  // data_o doubles as the keeper level when the bus floats
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      data_o    <= {DW{1'b0}};
      keep_oe_o <= 1'b0;
    end else begin
      if (load && req_write_i) begin
        data_o <= req_wdata_i;
      end else if (!(data_oe_o || wdrv_d)) begin
        // track the floated bus so the keeper holds its last level
        data_o <= data_s;
      end
      // keeper is weak; it only drives while the bus floats
      keep_oe_o <= keep_en_i && !wdrv_d;
    end
  end

  // ********************************************************
  // read data and completion
  // ********************************************************
  // the synchroniser lags two cycles, so END2 sees the last
  // strobe cycle's bus value
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      done_o  <= 1'b0;
      rdata_o <= {DW{1'b0}};
    end else begin
      done_o <= (state_q == ST_END2);
      if ((state_q == ST_END2) && !write_q) begin
        rdata_o <= data_s;
      end
    end
  end

endmodule

`default_nettype wire

//--- verification/ext_bus_ctrl_asserts.sv
// checker of the external bus control pins
`timescale 1ns/1ps
`default_nettype none

module ext_bus_ctrl_asserts #(
  parameter AW = 23
) (
  input wire          core_clk_i,
  input wire          srst_i,
  input wire          off_n_i,
  input wire          done_o,
  input wire          data_space_sel_n_o,
  input wire          program_space_sel_n_o,
  input wire          io_space_sel_n_o,
  input wire          memory_strobe_n_o,
  input wire          io_strobe_n_o,
  input wire          rw_o,
  input wire          ctrl_oe_o,
  input wire [AW-1:0] addr_o,
  input wire          addr_oe_o,
  input wire          data_oe_o,
  input wire          bus_grant_n_o,
  input wire          bus_grant_oe_o,
  input wire          microstate_done_n_o,
  input wire          microstate_done_oe_o
);
  // high while no space is being accessed
  wire sel_idle = data_space_sel_n_o & program_space_sel_n_o & io_space_sel_n_o;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // ********************************
  // select and strobe relations
  // ********************************
  property p_one_space;
    $onehot0({~data_space_sel_n_o, ~program_space_sel_n_o, ~io_space_sel_n_o});
  endproperty
  a_one_space: assert property (p_one_space) else $error("two spaces selected");
  // address may not move while a select stays low
  property p_addr_steady;
    (!sel_idle && $past(!sel_idle)) |-> $stable(addr_o);
  endproperty
  a_addr_steady: assert property (p_addr_steady) else $error("address moved");
  property p_mem_strobe;
    !memory_strobe_n_o |-> (!data_space_sel_n_o || !program_space_sel_n_o);
  endproperty
  a_mem_strobe: assert property (p_mem_strobe) else $error("stray memory strobe");
  property p_io_strobe;
    !io_strobe_n_o |-> !io_space_sel_n_o;
  endproperty
  a_io_strobe: assert property (p_io_strobe) else $error("stray io strobe");
  property p_rw_write;
    !rw_o |-> !sel_idle;
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("write outside access");

  // ********************************
  // wait states and access end
  // ********************************
  // done pulse of one cycle, inside an access
  property p_msc_one;
    $fell(microstate_done_n_o) |-> !sel_idle ##1 microstate_done_n_o;
  endproperty
  a_msc_one: assert property (p_msc_one) else $error("bad microstate done");
  property p_end_done;
    $rose(sel_idle) |-> ##2 done_o;
  endproperty
  a_end_done: assert property (p_end_done) else $error("late end of access");

  // ********************************
  // floating in hold and disable
  // ********************************
  property p_grant_float;
    !bus_grant_n_o |-> !ctrl_oe_o && !addr_oe_o && !data_oe_o;
  endproperty
  a_grant_float: assert property (p_grant_float) else $error("driving in hold");
  // three cycles of sync and register lag, so four low samples
  property p_off_float;
    !off_n_i [*4] |-> !(ctrl_oe_o | addr_oe_o | data_oe_o | bus_grant_oe_o | microstate_done_oe_o);
  endproperty
  a_off_float: assert property (p_off_float) else $error("driving when off");
endmodule

`default_nettype wire

//--- verification/bus_far_side.sv
// far-side model: memory, io device and ready source
`timescale 1ns/1ps
`default_nettype none

module bus_far_side (
  input  wire        core_clk_i,
  input  wire [1:0]  rdy_mode_i,  // 0 ready, 1 looped done, 2 never ready
  input  wire        sel_idle_i,  // all space selects high
  input  wire        rw_i,
  input  wire        ctrl_oe_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] pin_data_i,  // data driven by the block
  input  wire        data_oe_i,
  input  wire        keep_oe_i,
  input  wire        msc_n_i,
  input  wire        msc_oe_i,
  output wire        ready_o,
  output wire [15:0] bus_o,       // resolved data lines
  output reg  [15:0] wdata_o      // last word written to us
);
  reg [15:0] last_q = 16'h0000;  // level seen last cycle
  wire answer = ctrl_oe_i & ~sel_idle_i & rw_i;  // selected read
  // a floated done line reads high through its pull-up
  assign ready_o = (rdy_mode_i == 2'h1) ? (~msc_oe_i | msc_n_i) : (rdy_mode_i == 2'h0);
  // strong drive, then our answer, then the keeper, else a moving pattern
  assign bus_o = data_oe_i ? pin_data_i : answer ? (addr_i ^ 16'h5A3C) :
                 keep_oe_i ? pin_data_i : ~last_q;
  // capture writes while selected
  always @(posedge core_clk_i) begin
    last_q <= bus_o;
    if (ctrl_oe_i & ~sel_idle_i & ~rw_i & data_oe_i) begin
      wdata_o <= pin_data_i;
    end
  end
endmodule

`default_nettype wire

//--- verification/external_memory_bus_control_tb_top.sv
// testbench of the external bus control block
`timescale 1ns/1ps
`default_nettype none

module external_memory_bus_control_tb_top;
  logic core_clk_i = 1'b0, srst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
  logic keep_en_i = 1'b0, hold_n_i = 1'b1, off_n_i = 1'b1;
  logic [1:0] req_space_i = 2'h0, rdy_mode = 2'h0;
  logic [22:0] req_addr_i = 23'h000000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [2:0] req_wait_i = 3'h0, rws;
  wire req_ready_o, done_o, ready_i, rw_o, ctrl_oe_o, addr_oe_o, data_oe_o, keep_oe_o;
  wire data_space_sel_n_o, program_space_sel_n_o, io_space_sel_n_o, memory_strobe_n_o;
  wire io_strobe_n_o, bus_grant_n_o, bus_grant_oe_o, microstate_done_n_o;
  wire microstate_done_oe_o;
  wire [15:0] data_i, data_o, rdata_o, far_wdata;
  wire [22:0] addr_o;
  wire sel_idle = data_space_sel_n_o & program_space_sel_n_o & io_space_sel_n_o;
  integer n_mismatch = 0, cmp_count = 0, seed = 32'hdff9, cyc = 0, i;

  ext_bus_ctrl dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_space_i(req_space_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_wait_i(req_wait_i), .keep_en_i(keep_en_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o), .ready_i(ready_i),
    .hold_n_i(hold_n_i), .off_n_i(off_n_i), .data_i(data_i),
    .data_space_sel_n_o(data_space_sel_n_o), .program_space_sel_n_o(program_space_sel_n_o),
    .io_space_sel_n_o(io_space_sel_n_o), .memory_strobe_n_o(memory_strobe_n_o),
    .io_strobe_n_o(io_strobe_n_o), .rw_o(rw_o), .ctrl_oe_o(ctrl_oe_o), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .data_o(data_o), .data_oe_o(data_oe_o), .keep_oe_o(keep_oe_o),
    .bus_grant_n_o(bus_grant_n_o), .bus_grant_oe_o(bus_grant_oe_o),
    .microstate_done_n_o(microstate_done_n_o), .microstate_done_oe_o(microstate_done_oe_o));
  bus_far_side far (.core_clk_i(core_clk_i), .rdy_mode_i(rdy_mode), .sel_idle_i(sel_idle),
    .rw_i(rw_o), .ctrl_oe_i(ctrl_oe_o), .addr_i(addr_o[15:0]), .pin_data_i(data_o),
    .data_oe_i(data_oe_o), .keep_oe_i(keep_oe_o), .msc_n_i(microstate_done_n_o),
    .msc_oe_i(microstate_done_oe_o), .ready_o(ready_i), .bus_o(data_i), .wdata_o(far_wdata));

  // ********************************
  // clock, timeout and reporting
  // ********************************
  always #12.5 core_clk_i = ~core_clk_i;
  // a hang is cut short well beyond the few hundred cycles needed
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t timeout", $time);
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input logic ok, input string msg);
    begin
      cmp_count = cmp_count + 1;
      if (ok !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t %s", $time, msg);
      end
    end
  endtask
  // edges from the take edge to the edge that sees done
  function integer lat(input [2:0] w, input lp);
    lat = 4 + w + ((w >= 3'h2) ? (lp ? 3 : 2) : 0);
  endfunction

  // ********************************
  // one whole access with its checks
  // ********************************
  task access(input [1:0] sp, input wr, input [2:0] ws, input [1:0] md);
    integer n;
    logic [22:0] ad;
    logic [15:0] wd;
    begin
      ad = $random(seed);  // upper lines random in every space
      wd = $random(seed);
      rdy_mode <= md;
      req_valid_i <= 1'b1;
      req_space_i <= sp;
      req_write_i <= wr;
      req_addr_i <= ad;
      req_wdata_i <= wd;
      req_wait_i <= ws;
      n = 0;
      // request is held until taken
      do begin
        @(posedge core_clk_i);
        n = n + 1;
      end while (req_ready_o !== 1'b1 && n < 40);
      req_valid_i <= 1'b0;
      @(posedge core_clk_i);
      chk({data_space_sel_n_o, program_space_sel_n_o, io_space_sel_n_o} ===
          ~(3'h4 >> sp), "space select");
      chk(memory_strobe_n_o === (sp == 2'h2), "memory strobe");
      chk(io_strobe_n_o === (sp != 2'h2), "io strobe");
      chk(rw_o === !wr, "direction");
      chk(addr_o === {(sp == 2'h1) ? ad[22:16] : 7'h00, ad[15:0]}, "address");
      n = 1;
      while (done_o !== 1'b1 && n < 40) begin
        @(posedge core_clk_i);
        n = n + 1;
      end
      chk(n == lat(ws, md == 2'h1), "access length");
      chk(sel_idle === 1'b1, "select released");
      if (wr) chk(far_wdata === wd, "write data");
      else chk(rdata_o === (ad[15:0] ^ 16'h5A3C), "read data");
    end
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (5) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    // corners: every space and direction, waits 0 1 2 7, ready never, high and looped
    for (i = 0; i < 12; i = i + 1) begin
      rws = (i % 4 == 3) ? 3'h7 : i % 4;
      access(i % 3, i / 6, rws, (i % 4 < 2) ? 2'h2 : ((i / 4 == 1) ? 2'h0 : 2'h1));
    end
    $display("corner accesses done");
    for (i = 0; i < 24; i = i + 1) begin
      rws = $random(seed);
      keep_en_i <= $random(seed);
      access({$random(seed)} % 3, $random(seed), rws, {$random(seed)} % ((rws < 2) ? 3 : 2));
    end
    $display("random accesses done");
    // outside master takes the bus and keeps it while it needs it
    keep_en_i <= 1'b1;
    hold_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(bus_grant_n_o === 1'b0 && bus_grant_oe_o === 1'b1, "grant");
    chk({ctrl_oe_o, addr_oe_o, data_oe_o} === 3'h0, "float in hold");
    chk(keep_oe_o === 1'b1 && req_ready_o === 1'b0, "keeper in hold");
    hold_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk(bus_grant_n_o === 1'b1 && ctrl_oe_o === 1'b1, "hold release");
    $display("hold test done");
    off_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk({ctrl_oe_o, addr_oe_o, data_oe_o, bus_grant_oe_o, microstate_done_oe_o} === 5'h00,
        "float when off");
    off_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk(ctrl_oe_o === 1'b1 && addr_oe_o === 1'b1, "drive after off");
    $display("disable test done");
    give_verdict;
  end
endmodule

bind ext_bus_ctrl ext_bus_ctrl_asserts #(.AW(AW)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .off_n_i(off_n_i), .done_o(done_o),
  .data_space_sel_n_o(data_space_sel_n_o), .program_space_sel_n_o(program_space_sel_n_o),
  .io_space_sel_n_o(io_space_sel_n_o), .memory_strobe_n_o(memory_strobe_n_o),
  .io_strobe_n_o(io_strobe_n_o), .rw_o(rw_o), .ctrl_oe_o(ctrl_oe_o), .addr_o(addr_o),
  .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o), .bus_grant_n_o(bus_grant_n_o),
  .bus_grant_oe_o(bus_grant_oe_o), .microstate_done_n_o(microstate_done_n_o),
  .microstate_done_oe_o(microstate_done_oe_o));

`default_nettype wire
